// ---- hw/acpp_ctrl_port.sv ----
/*
 Control port of a mono amplifier: strap-selected two-wire or serial peripheral link,
 strapped target address latched at shutdown release, optional broadcast address,
 checksum of received two-wire bytes, and book/page register paging with pointer auto-increment.
 Assumes the analog front end turns the strap resistors into mode_strap_spi and
 addr_strap_level, and that the rest of the register space lives outside behind ext_*.
*/
`default_nettype none
// Contract
// - Strap grounded selects two-wire control; 470 ohm strap selects serial peripheral link.
// - Eight address strap levels map to addresses 0x70 to 0x7E in steps of two.
// - Listed addresses are the 7-bit address shifted left with a zero direction bit.
// - With broadcast enabled, also answer the shared address 0x80.
// - Clearing broadcast enable stops answers at the shared address; local address still works.
// - Keep a readable checksum over received two-wire command bytes.
// - Latch the target address from the strap when shutdown is released.
// - Writing the redetect bit high resamples the strap and updates the address.
// - Serial link samples input on falling edge and shifts output on rising edge.
// - Register space is pages of 128 locations, 256 pages per book.
// - Book zero selected after power-up and after a software reset.
// - Software-written 8-bit book and page selects steer later accesses.
module acpp_ctrl_port (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic shutdown_release_pin,
   input wire logic mode_strap_spi,
   input wire logic [acpp_pkg::ACPP_LEVEL_W-1:0] addr_strap_level,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic spi_sclk,
   input wire logic serial_select_n,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe,
   output logic spi_mode,
   output logic [6:0] target_id,
   output logic broadcast_target_enable,
   output logic [7:0] received_command_checksum,
   output logic [acpp_pkg::ACPP_SEL_W-1:0] book_sel,
   output logic [acpp_pkg::ACPP_SEL_W-1:0] page_sel,
   output logic ext_wr,
   output logic [acpp_pkg::ACPP_LOC_W-1:0] ext_loc,
   output logic [7:0] ext_wdata,
   input wire logic [7:0] ext_rdata
);
   import acpp_pkg::*;

   logic rst_meta, rst_n;
   logic scl_s, sda_s, sdz_s, mode_s;
   logic [ACPP_LEVEL_W-1:0] level_s;
   logic scl_d, sda_d, sdz_d;
   logic rx_tgl_s, ld_tgl_s, rx_tgl_d, ld_tgl_d;
   logic [7:0] spi_rx_byte;
   logic spi_rx_first, spi_rx_tgl, spi_ld_tgl;
   logic [7:0] spi_tx_byte;
   logic spi_rw, redetect;
   logic [6:0] ptr;
   acpp_i2c_st_t state, next_state;
   logic [3:0] bitcnt, next_bitcnt;
   logic [7:0] sh, next_sh;
   logic rw, next_rw, first_byte, next_first, next_sda_oe;

   // Reset release through two flops
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // Pins into the system clock; bus lines idle high
   acpp_sync2 #(.W(7), .INIT(7'h60)) u_pin_sync (
      .clk(mclk),
      .rst_n(rst_n),
      .d({scl_in, sda_in, shutdown_release_pin, mode_strap_spi, addr_strap_level}),
      .q({scl_s, sda_s, sdz_s, mode_s, level_s})
   );

   // Byte and load toggles from the link clock
   acpp_sync2 #(.W(2), .INIT(2'h0)) u_tgl_sync (
      .clk(mclk),
      .rst_n(rst_n),
      .d({spi_rx_tgl, spi_ld_tgl}),
      .q({rx_tgl_s, ld_tgl_s})
   );

   acpp_spi_link u_spi (
      .sclk(spi_sclk),
      .link_rst_n(rst_n),
      .serial_select_n(serial_select_n),
      .sdi(spi_sdi),
      .tx_byte(spi_tx_byte),
      .sdo(spi_sdo),
      .sdo_oe(spi_sdo_oe),
      .rx_byte(spi_rx_byte),
      .rx_first(spi_rx_first),
      .rx_tgl(spi_rx_tgl),
      .ld_tgl(spi_ld_tgl)
   );

   // Edge and condition detection on synchronised lines
   wire logic scl_rise = scl_s & ~scl_d;
   wire logic scl_fall = ~scl_s & scl_d;
   wire logic i2c_start = scl_s & scl_d & sda_d & ~sda_s;
   wire logic i2c_stop = scl_s & scl_d & ~sda_d & sda_s;
   wire logic sdz_rise = sdz_s & ~sdz_d;
   wire logic spi_rx_ev = spi_mode & (rx_tgl_s ^ rx_tgl_d);
   wire logic spi_ld_ev = spi_mode & (ld_tgl_s ^ ld_tgl_d);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         {scl_d, sda_d, sdz_d} <= 3'h6;
         {rx_tgl_d, ld_tgl_d} <= 2'h0;
      end else begin
         {scl_d, sda_d, sdz_d} <= {scl_s, sda_s, sdz_s};
         {rx_tgl_d, ld_tgl_d} <= {rx_tgl_s, ld_tgl_s};
      end
   end

   // Strap decode: 7-bit address is base plus level
   wire logic [6:0] next_target_id = ACPP_ID_BASE + {4'h0, level_s};

   // Mode captured at shutdown release; address at shutdown release or on redetect
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         spi_mode <= 1'b0;
         target_id <= ACPP_ID_BASE;
      end else begin
         if (sdz_rise) spi_mode <= mode_s;
         if (sdz_rise | redetect) target_id <= next_target_id;
      end
   end

   // Address match: local always, shared only while enabled
   wire logic addr_match = (sh[7:1] == target_id) |
      (broadcast_target_enable & (sh[7:1] == ACPP_ID_GLOBAL));

   // Common access events from either link
   wire logic i2c_byte_done = ~spi_mode & (state == ST_WRITE) & scl_fall & (bitcnt == ACPP_BPB);
   wire logic i2c_rd_done = ~spi_mode & (state == ST_READ) & scl_fall & (bitcnt == ACPP_BPB);
   wire logic wr_go = (i2c_byte_done & ~first_byte) | (spi_rx_ev & ~spi_rx_first & ~spi_rw);
   wire logic [7:0] wr_data = spi_mode ? spi_rx_byte : sh;
   wire logic ptr_load = (i2c_byte_done & first_byte) | (spi_rx_ev & spi_rx_first);
   wire logic [6:0] ptr_load_val = spi_mode ? spi_rx_byte[6:0] : sh[6:0];
   wire logic ptr_inc = wr_go | i2c_rd_done | spi_ld_ev;

   // Register decode; paging registers are visible in every page
   wire logic on_cfg = (book_sel == ACPP_BOOK_CFG) && (page_sel == ACPP_PAGE_CFG);
   wire logic hit_page = (ptr == ACPP_LOC_PAGE);
   wire logic hit_book = (ptr == ACPP_LOC_BOOK);
   wire logic hit_ctrl = on_cfg && (ptr == ACPP_LOC_CTRL);
   wire logic hit_swrst = on_cfg && (ptr == ACPP_LOC_SWRST);
   wire logic hit_cksum = on_cfg && (ptr == ACPP_LOC_CKSUM);
   wire logic hit_id = on_cfg && (ptr == ACPP_LOC_ID);
   wire logic hit_local = hit_page | hit_book | hit_ctrl | hit_swrst | hit_cksum | hit_id;
   wire logic wr_page = wr_go & hit_page;
   wire logic wr_book = wr_go & hit_book;
   wire logic wr_ctrl = wr_go & hit_ctrl;
   wire logic wr_swrst = wr_go & hit_swrst & wr_data[ACPP_SWRST_BIT];
   wire logic wr_cksum = wr_go & hit_cksum;

   // Read selection
   wire logic [7:0] rd_byte = hit_page ? page_sel :
      hit_book ? book_sel :
      hit_ctrl ? {7'h00, broadcast_target_enable} :
      hit_cksum ? received_command_checksum :
      hit_id ? {1'b0, target_id} :
      hit_swrst ? 8'h00 : ext_rdata;
   wire logic [3:0] rd_idx = ACPP_BPB - 4'h1 - bitcnt;

   // Book, page and control bits; soft reset returns to book 0
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         book_sel <= ACPP_BOOK_CFG;
         page_sel <= ACPP_PAGE_CFG;
         broadcast_target_enable <= ACPP_BCAST_RST;
         redetect <= 1'b0;
      end else if (wr_swrst) begin
         book_sel <= ACPP_BOOK_CFG;
         page_sel <= ACPP_PAGE_CFG;
         redetect <= 1'b0;
      end else begin
         if (wr_page) page_sel <= wr_data;
         if (wr_book) book_sel <= wr_data;
         if (wr_ctrl) broadcast_target_enable <= wr_data[ACPP_CTRL_BCAST];
         redetect <= wr_ctrl & wr_data[ACPP_CTRL_REDET];
      end
   end

   // Checksum of received two-wire bytes; the hardware update wins over a write
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) received_command_checksum <= ACPP_CKSUM_RST;
      else if (i2c_byte_done) received_command_checksum <= acpp_crc8(received_command_checksum, sh);
      else if (wr_cksum) received_command_checksum <= wr_data;
   end

   // Location pointer: loaded by the first byte, then steps per data byte
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ptr <= ACPP_LOC_RST;
         spi_rw <= 1'b0;
      end else if (ptr_load) begin
         ptr <= ptr_load_val;
         spi_rw <= spi_rx_byte[7];
      end else if (ptr_inc) begin
         ptr <= ptr + 7'h1;
      end
   end

   // Outside register space and the read word offered to the link clock
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ext_wr <= 1'b0;
         ext_loc <= ACPP_LOC_RST;
         ext_wdata <= 8'h00;
         spi_tx_byte <= 8'h00;
      end else begin
         ext_wr <= wr_go & ~hit_local;
         ext_loc <= ptr;
         ext_wdata <= wr_data;
         spi_tx_byte <= rd_byte;
      end
   end

   // Two-wire target sequencing
   always_comb begin
      next_state = state;
      next_bitcnt = bitcnt;
      next_sh = sh;
      next_rw = rw;
      next_first = first_byte;
      next_sda_oe = sda_oe;
      if (spi_mode | i2c_stop) begin
         next_state = ST_IDLE;
         next_sda_oe = 1'b0;
      end else if (i2c_start) begin
         next_state = ST_ADDR;
         next_bitcnt = 4'h0;
         next_sda_oe = 1'b0;
      end else begin
         if (scl_rise) next_bitcnt = bitcnt + 4'h1;
         if (scl_rise && (state == ST_ADDR || state == ST_WRITE)) next_sh = {sh[6:0], sda_s};
         case (state)
            ST_ADDR: begin
               if (scl_fall && bitcnt == ACPP_BPB) begin
                  next_state = addr_match ? ST_ACKA : ST_IDLE;
                  next_sda_oe = addr_match;
                  next_rw = sh[0];
               end
            end
            ST_ACKA: begin
               if (scl_fall) begin
                  next_bitcnt = 4'h0;
                  next_first = 1'b1;
                  next_state = rw ? ST_READ : ST_WRITE;
                  next_sda_oe = rw & ~rd_byte[7];
               end
            end
            ST_WRITE: begin
               if (scl_fall && bitcnt == ACPP_BPB) begin
                  next_state = ST_ACKW;
                  next_sda_oe = 1'b1;
               end
            end
            ST_ACKW: begin
               if (scl_fall) begin
                  next_state = ST_WRITE;
                  next_bitcnt = 4'h0;
                  next_first = 1'b0;
                  next_sda_oe = 1'b0;
               end
            end
            ST_READ: begin
               if (scl_fall && bitcnt == ACPP_BPB) begin
                  next_state = ST_ACKR;
                  next_sda_oe = 1'b0;
               end else if (scl_fall) begin
                  next_sda_oe = ~rd_byte[rd_idx[2:0]];
               end
            end
            ST_ACKR: begin
               if (scl_rise && sda_s) begin
                  next_state = ST_IDLE;
               end else if (scl_fall) begin
                  next_state = ST_READ;
                  next_bitcnt = 4'h0;
                  next_sda_oe = ~rd_byte[7];
               end
            end
            ST_IDLE: begin
               next_state = ST_IDLE;
            end
            default: begin
               next_state = ST_IDLE;
               next_sda_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         bitcnt <= 4'h0;
         sh <= 8'h00;
         rw <= 1'b0;
         first_byte <= 1'b0;
         sda_oe <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         state <= next_state;
         bitcnt <= next_bitcnt;
         sh <= next_sh;
         rw <= next_rw;
         first_byte <= next_first;
         sda_oe <= next_sda_oe;
         sda_out <= 1'b0;
      end
   end

   // Checks
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);

   wire logic addr_slot = (state == ST_ADDR) && scl_fall && (bitcnt == ACPP_BPB) &&
      !spi_mode && !i2c_start && !i2c_stop;

   a_mode_strap:
   assert property (sdz_rise |=> spi_mode == $past(mode_s))
      else $error("mode not taken from strap at shutdown release");
   a_id_latch:
   assert property (sdz_rise |=> target_id == ACPP_ID_BASE + {4'h0, $past(level_s)})
      else $error("address not latched at shutdown release");
   a_id_redetect:
   assert property ((wr_ctrl && wr_data[ACPP_CTRL_REDET] && !wr_swrst) |->
      ##2 target_id == ACPP_ID_BASE + {4'h0, $past(level_s)})
      else $error("redetect did not resample the strap");
   a_local_ack:
   assert property ((addr_slot && sh[7:1] == target_id) |=> state == ST_ACKA && sda_oe)
      else $error("local address not acknowledged");
   a_global_ack:
   assert property ((addr_slot && broadcast_target_enable && sh[7:1] == ACPP_ID_GLOBAL) |=>
      state == ST_ACKA && sda_oe)
      else $error("shared address not acknowledged while enabled");
   a_global_off:
   assert property ((addr_slot && !broadcast_target_enable && sh[7:1] == ACPP_ID_GLOBAL &&
      target_id != ACPP_ID_GLOBAL) |=> state == ST_IDLE && !sda_oe)
      else $error("shared address answered while disabled");
   a_crc_update:
   assert property (i2c_byte_done |=>
      received_command_checksum == acpp_crc8($past(received_command_checksum), $past(sh)))
      else $error("checksum not updated by received byte");
   a_page_write:
   assert property ((wr_page && !wr_swrst) |=> page_sel == $past(wr_data))
      else $error("page select not written");
   a_soft_reset:
   assert property (wr_swrst |=> book_sel == ACPP_BOOK_CFG && page_sel == ACPP_PAGE_CFG)
      else $error("soft reset did not return to book zero");
   a_ptr_step:
   assert property ((wr_go && !ptr_load) |=> ptr == $past(ptr) + 7'h1)
      else $error("pointer did not advance after data byte");
endmodule
`default_nettype wire

// ---- hw/acpp_pkg.sv ----
/*
 Shared constants, state type and checksum function of the amplifier control port with
 book/page register paging. Assumes a single 10 MHz system clock for the control logic.
*/
`default_nettype none
package acpp_pkg;
   // Peripheral address: 7-bit form, equal to the printed 8-bit value divided by two
   localparam logic [6:0] ACPP_ID_BASE = 7'h38;
   localparam logic [6:0] ACPP_ID_GLOBAL = 7'h40;
   localparam int ACPP_LEVEL_W = 3;
   // In-page location, book and page widths
   localparam int ACPP_LOC_W = 7;
   localparam int ACPP_SEL_W = 8;
   // Locations of the port's own registers
   localparam logic [6:0] ACPP_LOC_PAGE = 7'h00;
   localparam logic [6:0] ACPP_LOC_SWRST = 7'h01;
   localparam logic [6:0] ACPP_LOC_CTRL = 7'h02;
   localparam logic [6:0] ACPP_LOC_CKSUM = 7'h03;
   localparam logic [6:0] ACPP_LOC_ID = 7'h04;
   localparam logic [6:0] ACPP_LOC_BOOK = 7'h7F;
   // Field positions
   localparam int ACPP_CTRL_BCAST = 0;
   localparam int ACPP_CTRL_REDET = 1;
   localparam int ACPP_SWRST_BIT = 0;
   // Reset values; book 0 and page 0 hold the configuration
   localparam logic [7:0] ACPP_BOOK_CFG = 8'h00;
   localparam logic [7:0] ACPP_PAGE_CFG = 8'h00;
   localparam logic ACPP_BCAST_RST = 1'b0;
   localparam logic [7:0] ACPP_CKSUM_RST = 8'h00;
   localparam logic [6:0] ACPP_LOC_RST = 7'h00;
   // Serial framing
   localparam logic [3:0] ACPP_BPB = 4'h8;
   localparam logic [7:0] ACPP_CRC_POLY = 8'h07;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_ADDR = 7'h02,
      ST_ACKA = 7'h04,
      ST_WRITE = 7'h08,
      ST_ACKW = 7'h10,
      ST_READ = 7'h20,
      ST_ACKR = 7'h40
   } acpp_i2c_st_t;

   // Bitwise CRC-8 step over one received byte
   function automatic logic [7:0] acpp_crc8(input logic [7:0] crc, input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ ACPP_CRC_POLY) : (c << 1);
      end
      return c;
   endfunction
endpackage
`default_nettype wire

// ---- hw/acpp_sync2.sv ----
/*
 Two-flop level synchroniser, W bits wide, with a settable reset value.
 Assumes every bit is a slow level or a toggle, never a multi-bit word in flight.
*/
`default_nettype none
module acpp_sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= INIT;
         q <= INIT;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule
`default_nettype wire

// ---- hw/acpp_spi_link.sv ----
/*
 Serial peripheral link on its own clock: shifts bytes in and out, hands each received
 byte to the system side by a toggle, and loads read bytes from a word held stable there.
 Assumes the clock idles low and moves only while the select is low.
*/
`default_nettype none
module acpp_spi_link (
   input wire logic sclk,
   input wire logic link_rst_n,
   input wire logic serial_select_n,
   input wire logic sdi,
   input wire logic [7:0] tx_byte,
   output logic sdo,
   output logic sdo_oe,
   output logic [7:0] rx_byte,
   output logic rx_first,
   output logic rx_tgl,
   output logic ld_tgl
);
   import acpp_pkg::*;

   logic [2:0] bcnt;
   logic [6:0] shin;
   logic [6:0] txsh;
   logic [1:0] idx;
   logic rw;

   wire logic byte_end = (bcnt == 3'h7);
   wire logic rd_data_byte = rw && (idx == 2'h2);

   // Input shifter on the falling edge, cleared while deselected
   always_ff @(negedge sclk or posedge serial_select_n) begin
      if (serial_select_n) begin
         bcnt <= 3'h0;
         shin <= 7'h00;
         idx <= 2'h0;
         rw <= 1'b0;
      end else begin
         shin <= {shin[5:0], sdi};
         bcnt <= bcnt + 3'h1;
         if (byte_end && idx != 2'h2) idx <= idx + 2'h1;
         if (byte_end && idx == 2'h0) rw <= shin[6];
      end
   end

   // Completed byte handed over with a toggle
   always_ff @(negedge sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         rx_byte <= 8'h00;
         rx_first <= 1'b0;
         rx_tgl <= 1'b0;
      end else if (!serial_select_n && byte_end) begin
         rx_byte <= {shin, sdi};
         rx_first <= (idx == 2'h0);
         rx_tgl <= ~rx_tgl;
      end
   end

   // Output shifter on the rising edge
   always_ff @(posedge sclk or posedge serial_select_n) begin
      if (serial_select_n) begin
         sdo <= 1'b0;
         sdo_oe <= 1'b0;
         txsh <= 7'h00;
      end else begin
         sdo_oe <= 1'b1;
         if (bcnt == 3'h0) {sdo, txsh} <= rd_data_byte ? tx_byte : 8'h00;
         else {sdo, txsh} <= {txsh, 1'b0};
      end
   end

   // Each read byte taken announces itself so the pointer moves on
   always_ff @(posedge sclk or negedge link_rst_n) begin
      if (!link_rst_n) ld_tgl <= 1'b0;
      else if (!serial_select_n && bcnt == 3'h0 && rd_data_byte) ld_tgl <= ~ld_tgl;
   end
endmodule
`default_nettype wire

// ---- dv/acpp_host_model.sv ----
/*
 Host controller model for the control port: serial peripheral link and two-wire bus.
 Assumes the testbench calls one task at a time and wires SDA as an open-drain line.
*/
`default_nettype none
module acpp_host_model (
   output logic sclk,
   output logic sel_n,
   output logic sdi,
   input wire logic sdo,
   output logic scl,
   output logic sda_drv,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HALF = 1000;
   // Idle: link clock parked low, select high, bus released
   initial begin
      sclk = 1'b0;
      sel_n = 1'b1;
      sdi = 1'b0;
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // One byte, MSB first: data moves after the rise, is taken at the fall
   task automatic spi_byte(input logic [7:0] d, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) begin
         #16 sclk = 1'b1;
         #16 sdi = d[i];
         #16 sclk = 1'b0;
         q[i] = sdo;
         #16;
      end
   endtask
   // Framed transfer; clock stands still outside the frame, returns the last byte read
   task automatic spi_frame(input logic [7:0] tx[$], output logic [7:0] last);
      sel_n = 1'b0;
      #64;
      foreach (tx[k]) spi_byte(tx[k], last);
      #64 sel_n = 1'b1;
      sdi = ~sdi;  // Released line no longer shows the last bit
      #256;
   endtask
   // One bus bit: data changes while the clock is low, read on the high phase
   task automatic i2c_bit(input logic b, output logic r);
      #(HALF / 4) sda_drv = b;
      #(HALF * 3 / 4) scl = 1'b1;
      r = sda;
      #HALF scl = 1'b0;
   endtask
   // Write transfer: start, address byte, payload bytes, stop; returns the address ACK
   task automatic i2c_write(input logic [6:0] id, input logic [7:0] tx[$], output logic ack);
      logic r;
      logic [7:0] b;
      sda_drv = 1'b0;
      #HALF scl = 1'b0;
      b = {id, 1'b0};
      for (int k = -1; k < tx.size(); k++) begin
         if (k >= 0) b = tx[k];
         for (int i = 7; i >= 0; i--) i2c_bit(b[i], r);
         i2c_bit(1'b1, r);
         if (k < 0) ack = ~r;
      end
      #(HALF / 4) sda_drv = 1'b0;
      #HALF scl = 1'b1;
      #HALF sda_drv = 1'b1;
      #HALF;
   endtask
endmodule
`default_nettype wire

// ---- dv/acpp_ctrl_port_tb.sv ----
/*
 Self-checking bench of the control port: strap decode, paging, pointer, broadcast, checksum.
 Assumes the host model as far side and a combinational outside register file.
*/
`default_nettype none
module acpp_ctrl_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0, arst_n = 1'b0, sd_pin = 1'b0, mode_spi = 1'b1;
   logic [2:0] lvl = 3'h0;
   logic scl, sda_drv, sda, sclk, sel_n, sdi, sdo, spi_mode, bc_en, ext_wr;
   logic [6:0] tid, ext_loc;
   logic [7:0] cksum, book, page, ext_wdata, ext_rdata;
   logic [15:0] wq[$];
   int bad_count = 0, n_tests = 0, cycles = 0;
   logic sda_oe_w, sda_out_w, sdo_oe, sdo_line;
   // Open-drain line with pull-up; an idle serial output shows the inverse of sdo, which deselect clears, so it reads high
   assign sda = sda_drv & (sda_oe_w ? sda_out_w : 1'b1);
   assign sdo_line = sdo_oe ? sdo : ~sdo;
   assign ext_rdata = {1'b0, ext_loc} ^ 8'h5A;
   acpp_ctrl_port acpp_ctrl_port_i (.mclk(mclk), .arst_n(arst_n), .shutdown_release_pin(sd_pin),
      .mode_strap_spi(mode_spi), .addr_strap_level(lvl), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out_w), .sda_oe(sda_oe_w), .spi_sclk(sclk), .serial_select_n(sel_n),
      .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .spi_mode(spi_mode), .target_id(tid),
      .broadcast_target_enable(bc_en), .received_command_checksum(cksum), .book_sel(book),
      .page_sel(page), .ext_wr(ext_wr), .ext_loc(ext_loc), .ext_wdata(ext_wdata),
      .ext_rdata(ext_rdata));
   acpp_host_model acpp_host_model_i (.sclk(sclk), .sel_n(sel_n), .sdi(sdi), .sdo(sdo_line),
      .scl(scl), .sda_drv(sda_drv), .sda(sda));
   always #50 mclk = ~mclk;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
   endtask
   function automatic int crc_step(input int c, input int d);
      c = (c ^ d) & 255;
      repeat (8) c = (c & 128) ? ((c << 1) ^ 7) & 255 : (c << 1) & 255;
      return c;
   endfunction
   // Every outside write must match the next expected location and data
   always @(posedge mclk) begin
      if (ext_wr === 1'b1) chk({1'b0, ext_loc, ext_wdata}, wq.pop_front());
   end
   // Hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         complete_run();
      end
   end
   // Main sequence
   initial begin
      logic [7:0] r;
      logic [7:0] d[4];
      logic ack;
      int lv, p, b, crc;
      void'($urandom(88842));
      crc = 0;
      wt(12);
      arst_n <= 1'b1;
      wt(6);
      chk({8'h0, book}, 16'h0);
      lv = $urandom_range(7);
      lvl <= 3'(lv);
      sd_pin <= 1'b1;
      wt(8);
      chk({15'h0, spi_mode}, 16'h1);
      chk({9'h0, tid}, 16'((8'h70 + 2 * lv) >> 1));
      p = $urandom_range(1, 255);
      b = $urandom_range(1, 255);
      acpp_host_model_i.spi_frame('{8'h00, 8'(p)}, r);
      acpp_host_model_i.spi_frame('{8'h7F, 8'(b)}, r);
      wt(8);
      chk({book, page}, 16'({b[7:0], p[7:0]}));
      for (int k = 0; k < 4; k++) begin
         d[k] = 8'($urandom);
         wq.push_back({1'b0, 7'(16 + k), d[k]});
      end
      acpp_host_model_i.spi_frame('{8'h10, d[0], d[1], d[2], d[3]}, r);
      wt(8);
      chk(16'(wq.size()), 16'h0);
      acpp_host_model_i.spi_frame('{8'hA0, 8'h00, 8'h00, 8'h00}, r);
      chk({8'h0, r}, {8'h0, 8'h21 ^ 8'h5A});
      acpp_host_model_i.spi_frame('{8'h7F, 8'h00}, r);
      acpp_host_model_i.spi_frame('{8'h00, 8'h00, 8'h01, 8'h01}, r);
      wt(8);
      chk({15'h0, bc_en}, 16'h1);
      lv = (lv + $urandom_range(1, 7)) % 8;
      lvl <= 3'(lv);
      wt(4);
      acpp_host_model_i.spi_frame('{8'h02, 8'h02}, r);
      wt(8);
      chk({8'h0, bc_en, tid}, 16'((8'h70 + 2 * lv) >> 1));
      sd_pin <= 1'b0;
      mode_spi <= 1'b0;
      wt(8);
      sd_pin <= 1'b1;
      wt(8);
      chk({15'h0, spi_mode}, 16'h0);
      acpp_host_model_i.i2c_write(7'(56 + lv), '{8'h02, 8'h01}, ack);
      chk({15'h0, ack}, 16'h1);
      crc = crc_step(crc_step(crc, 2), 1);
      acpp_host_model_i.i2c_write(7'h40, '{8'h00, 8'h06}, ack);  // ACK not judged
      crc = crc_step(crc_step(crc, 0), 6);
      chk({8'h0, page}, 16'h6);
      acpp_host_model_i.i2c_write(7'(56 + lv) ^ 7'h01, '{8'h00, 8'h09}, ack);
      chk({7'h0, ack, page}, 16'h6);
      // Page 0, soft reset bit low, then broadcast enable cleared
      acpp_host_model_i.i2c_write(7'(56 + lv), '{8'h00, 8'h00, 8'h00, 8'h00}, ack);
      crc = crc_step(crc_step(crc_step(crc_step(crc, 0), 0), 0), 0);
      acpp_host_model_i.i2c_write(7'h40, '{8'h00, 8'h0B}, ack);
      chk({7'h0, bc_en, page}, 16'h0);
      chk({8'h0, cksum}, 16'(crc));
      complete_run();
   end
endmodule
`default_nettype wire
